// >>> hdl/keyed_watchdog_timer.sv
// Keyed watchdog timer with an AXI4-Lite register slave and event interrupt.
// Assumes one 10 MHz clock aclk, synchronous active-low aresetn, and that
// the system reset generator feeds back timeout_system_reset as a reset.
//
// Operation
// - 16-bit down counter decrements on each enabled tick
// - Tick from clock divided 8/32/128/1024 by select
// - Restart loads fff low and preload high nibble
// - Overflow requests system reset when reset enabled
// - Overflow pulses interrupt output when interrupt enabled
// - Overflow drives pin low eight cycles when enabled
// - Disabled timer starts no overflow signals; a pin pulse under way runs on
// - Mode and config writes need matching key
// - Mode enables update only with key 0x234
// - Config fields update only with key 0x06e
// - Restart only on control write of 0xc071
// - Overflow flag set on overflow, cleared on restart
// - Reset cause reports watchdog code after timeout
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module keyed_watchdog_timer #(
  // Master clock cycles the overflow pin is held low
  parameter int pin_low_len = wdog_pkg::pin_low_cycles
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset cause: high when the last reset came from this watchdog
  input wire logic last_reset_was_watchdog,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Overflow outputs
  output logic timeout_system_reset,
  output logic timeout_interrupt,
  output logic overflow_pin_n,
  // Event interrupt
  output logic irq
);
  import wdog_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divider length for a tick select code
  function automatic logic [10:0] tick_period(input logic [1:0] sel);
    case (sel)
      2'b00: tick_period = div_8;
      2'b01: tick_period = div_32;
      2'b10: tick_period = div_128;
      default: tick_period = div_1024;
    endcase
  endfunction

  // Preload value built from the high nibble
  // Low twelve bits are always ones, so even nibble 0 gives 4096 ticks
  function automatic logic [15:0] preload(input logic [3:0] hi);
    preload = {hi, preload_low_ones};
  endfunction

  // Word decode: true when a byte address selects the register at off
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = addr[7:2] == off[7:2];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  mode_type mode_q;
  logic [3:0] preload_high_nibble_q;
  logic [1:0] tick_divider_select_q;
  logic overflow_flag_q;
  logic [1:0] event_status_q;
  logic [1:0] event_mask_q;
  logic [7:0] reset_cause_q;
  logic [15:0] count_q;
  logic [10:0] div_q;
  logic [3:0] pin_cnt_q;
  overflow_out_type ovf_out_q;

  // Write channel latches; address and data may arrive in either order
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic lo_ok;
  logic tick;
  logic overflow;
  logic restart;
  logic mode_key_ok;
  logic config_key_ok;
  logic [10:0] tick_last;

  // Ready stays low while a response waits, so one write is in flight at most
  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign wr_fire = aw_held_q && w_held_q && !bvalid;
  // Keys sit in bits 15..4, so both low byte lanes must be written
  assign lo_ok = w_strb_q[0] && w_strb_q[1];
  // Key checks, shared by the register updates and the reject event
  assign mode_key_ok = lo_ok && w_data_q[15:mode_key_lsb] == mode_write_key;
  assign config_key_ok = lo_ok && w_data_q[15:config_key_lsb] == config_write_key;

  // Capture write address and data
  // Each channel is taken on its own handshake and held until the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      case ({aw_addr_q[7:2], 2'b00})
        overflow_mode_off, tick_config_off, restart_command_off,
        event_status_off, event_mask_off: bresp <= 2'b00;
        default: bresp <= 2'b10;
      endcase
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Mode register, guarded by its key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= mode_type'(mode_reset);
    end else if (wr_fire && addr_hit(aw_addr_q, overflow_mode_off) && mode_key_ok) begin
      mode_q <= mode_type'(w_data_q[3:0]);
    end
  end

  // Tick and preload configuration, guarded by its key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {preload_high_nibble_q, tick_divider_select_q} <= config_reset;
    end else if (wr_fire && addr_hit(aw_addr_q, tick_config_off) && config_key_ok) begin
      preload_high_nibble_q <= w_data_q[preload_lsb +: 4];
      tick_divider_select_q <= w_data_q[1:0];
    end
  end

  // Restart only on the exact password
  assign restart = wr_fire && addr_hit(aw_addr_q, restart_command_off) && lo_ok &&
                   w_data_q[15:0] == restart_password;

  // ----------------------------------------------------------------
  // Tick divider and counter
  // ----------------------------------------------------------------
  // Last count of the divider for the selected tap
  assign tick_last = tick_period(tick_divider_select_q) - 11'h001;

  // Divider restarts with the counter so the first tick is a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || restart || !mode_q.timer_enable) begin
      div_q <= 11'h000;
    end else if (div_q >= tick_last) begin
      div_q <= 11'h000;
    end else begin
      div_q <= div_q + 11'h001;
    end
  end

  // A disabled timer never ticks, so no overflow signal can follow
  assign tick = mode_q.timer_enable && div_q == tick_last;
  assign overflow = tick && count_q == 16'h0000;

  // Down counter; wraps to the preload on overflow and keeps running
  // Restart beats overflow so a late restart still buys a full period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= preload(4'h0);
    end else if (restart) begin
      count_q <= preload(preload_high_nibble_q);
    end else if (overflow) begin
      count_q <= preload(preload_high_nibble_q);
    end else if (tick) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // Overflow flag: a same-cycle overflow wins over restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow) begin
      overflow_flag_q <= 1'b1;
    end else if (restart) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Overflow signals, each gated by its own enable
  // ----------------------------------------------------------------
  // Registered so the pulses leave the block free of glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_out_q <= '{timeout_system_reset: 1'b0, timeout_interrupt: 1'b0,
                     overflow_pin_n: 1'b1};
      pin_cnt_q <= 4'h0;
    end else begin
      // Overflow needs timer_enable, so a disabled timer starts no new output pulse
      ovf_out_q.timeout_system_reset <= overflow && mode_q.reset_on_overflow_enable;
      ovf_out_q.timeout_interrupt <= overflow && mode_q.interrupt_on_overflow_enable;
      // Limitation: a pin pulse already started runs its full length
      if (overflow && mode_q.pin_on_overflow_enable) begin
        pin_cnt_q <= 4'(pin_low_len - 1);
        ovf_out_q.overflow_pin_n <= 1'b0;
      end else if (pin_cnt_q != 4'h0) begin
        pin_cnt_q <= pin_cnt_q - 4'h1;
      end else begin
        ovf_out_q.overflow_pin_n <= 1'b1;
      end
    end
  end

  assign timeout_system_reset = ovf_out_q.timeout_system_reset;
  assign timeout_interrupt = ovf_out_q.timeout_interrupt;
  assign overflow_pin_n = ovf_out_q.overflow_pin_n;

  // Reset cause caught after release, never under reset itself,
  // so a cause input that settles late during reset is still seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_q <= 8'h00;
    end else if (reset_cause_q == 8'h00) begin
      reset_cause_q <= last_reset_was_watchdog ? cause_watchdog : cause_pin;
    end
  end

  // ----------------------------------------------------------------
  // Event interrupt: bit 0 overflow, bit 1 rejected keyed write
  // ----------------------------------------------------------------
  logic key_reject;
  // A restart write with any other value counts as a rejected keyed write
  assign key_reject = wr_fire && !restart &&
    ((addr_hit(aw_addr_q, overflow_mode_off) && !mode_key_ok) ||
     (addr_hit(aw_addr_q, tick_config_off) && !config_key_ok) ||
     addr_hit(aw_addr_q, restart_command_off));

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status_q <= 2'b00;
    end else begin
      event_status_q <= (event_status_q &
        ~((wr_fire && addr_hit(aw_addr_q, event_status_off) && w_strb_q[0]) ?
          w_data_q[1:0] : 2'b00)) | {key_reject, overflow};
    end
  end

  // Interrupt mask; only bits set here drive the level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_mask_q <= 2'b00;
    end else if (wr_fire && addr_hit(aw_addr_q, event_mask_off) && w_strb_q[0]) begin
      event_mask_q <= w_data_q[1:0];
    end
  end

  assign irq = |(event_status_q & event_mask_q);

  // ----------------------------------------------------------------
  // Read channel: one cycle from address to data
  // ----------------------------------------------------------------
  // Reads never stall: the address is taken whenever no data waits
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'b00;
      // Key fields read back as zero
      case ({araddr[7:2], 2'b00})
        overflow_mode_off: rdata <= {28'h0, mode_q};
        tick_config_off: rdata <= {26'h0, preload_high_nibble_q, tick_divider_select_q};
        restart_command_off: rdata <= 32'h0000_0000;
        overflow_status_off: rdata <= {31'h0, overflow_flag_q};
        event_status_off: rdata <= {30'h0, event_status_q};
        event_mask_off: rdata <= {30'h0, event_mask_q};
        reset_cause_off: rdata <= {24'h0, reset_cause_q};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= 2'b10;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // keyed_watchdog_timer

// >>> hdl/wdog_pkg.sv
// Package for the keyed watchdog timer: register map, field layout, keys, timing.
// Assumes a 10 MHz master clock and a 32-bit AXI4-Lite register bus.
package wdog_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] overflow_mode_off = 8'h00;
  localparam logic [7:0] tick_config_off = 8'h04;
  localparam logic [7:0] restart_command_off = 8'h08;
  localparam logic [7:0] overflow_status_off = 8'h0c;
  localparam logic [7:0] event_status_off = 8'h10;
  localparam logic [7:0] event_mask_off = 8'h14;
  localparam logic [7:0] reset_cause_off = 8'h18;

  // ----------------------------------------------------------------
  // Keys and field positions
  // ----------------------------------------------------------------
  localparam logic [11:0] mode_write_key = 12'h234;
  localparam logic [8:0] config_write_key = 9'h06e;
  localparam logic [15:0] restart_password = 16'hc071;
  localparam int mode_key_lsb = 4;
  localparam int config_key_lsb = 7;
  localparam int preload_lsb = 2;
  localparam logic [11:0] preload_low_ones = 12'hfff;

  // Reset cause codes
  localparam logic [7:0] cause_pin = 8'h6c;
  localparam logic [7:0] cause_watchdog = 8'h53;

  // Reset values
  localparam logic [3:0] mode_reset = 4'h0;
  localparam logic [5:0] config_reset = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int clock_hz = 10_000_000;
  localparam int pin_low_cycles = 8;
  localparam logic [10:0] div_8 = 11'h008;
  localparam logic [10:0] div_32 = 11'h020;
  localparam logic [10:0] div_128 = 11'h080;
  localparam logic [10:0] div_1024 = 11'h400;

  // Overflow mode enable bits
  typedef struct packed {
    logic pin_on_overflow_enable;
    logic interrupt_on_overflow_enable;
    logic reset_on_overflow_enable;
    logic timer_enable;
  } mode_type;

  // Overflow outputs travelling together
  typedef struct packed {
    logic timeout_system_reset;
    logic timeout_interrupt;
    logic overflow_pin_n;
  } overflow_out_type;

endpackage

// >>> bench/wdog_props.sv
// Checker for the keyed watchdog: bus answer timing and overflow output shapes.
// Sees only ports of the top module; attached by the bind at the foot.
`timescale 1ns/1ns
module wdog_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Overflow outputs
  input wire logic timeout_system_reset,
  input wire logic timeout_interrupt,
  input wire logic overflow_pin_n
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin low for exactly eight cycles, then back high
  AST_PIN_LOW: assert property ($fell(overflow_pin_n) |->
    (!overflow_pin_n)[*8] ##1 overflow_pin_n)
    else $error("overflow pin low time wrong");
  AST_RST_PULSE: assert property (timeout_system_reset |=> !timeout_system_reset)
    else $error("reset request longer than one cycle");
  // One interrupt per overflow; the next cannot follow soon
  AST_IRQ_ONCE: assert property (timeout_interrupt |=> (!timeout_interrupt)[*8])
    else $error("interrupt pulse repeated");
  AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_AR_READY: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed after accept");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule // wdog_props
bind keyed_watchdog_timer wdog_props u_props (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .timeout_system_reset(timeout_system_reset),
  .timeout_interrupt(timeout_interrupt), .overflow_pin_n(overflow_pin_n));

// >>> bench/tb_top.sv
// Testbench for the keyed watchdog: register access, keys, overflow outputs.
// Assumes the 10 MHz clock; the bench stands in for the reset cause input.
`timescale 1ns/1ns
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic last_reset_was_watchdog = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, tsr, tint, pin_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0, tests_run = 0, ticks = 0, n_int, n_rst, n_pin, cyc, tail;
  keyed_watchdog_timer u_dut (.aclk(aclk), .aresetn(aresetn),
    .last_reset_was_watchdog(last_reset_was_watchdog), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timeout_system_reset(tsr), .timeout_interrupt(tint), .overflow_pin_n(pin_n), .irq(irq));
  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  always #50 aclk = ~aclk;
  // Two full timeouts take about 66k cycles, so 90k means a hang
  always @(posedge aclk) begin
    ticks++;
    if (ticks == 90000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ----------------------------------------------------------------
  // Bus tasks: bready/rready rise only after valid is seen, to test holding
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) awvalid <= 1'h0;
      if (!ad && awready) ad = 1'h1;
      if (!wd && wready) wvalid <= 1'h0;
      if (!wd && wready) wd = 1'h1;
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h1;
    @(posedge aclk);
    chk("bresp", bresp, er);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    chk("rresp", rresp, er);
    if (er == 2'h0) chk("rdata", rdata, exp);
    rready <= 1'h0;
  endtask
  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask
  // Start sequence, then count output activity until irq plus a tail
  task automatic run(input logic [31:0] mode);
    wr(8'h00, 32'h2340, 2'h0);
    wr(8'h04, 32'h3700, 2'h0);
    wr(8'h08, 32'hc071, 2'h0);
    wr(8'h10, 32'h3, 2'h0);
    wr(8'h00, mode, 2'h0);
    chk("irq_clear", irq, 1'h0);
    n_int = 0;
    n_rst = 0;
    n_pin = 0;
    cyc = 0;
    tail = 0;
    while (tail < 12 && cyc < 40000) begin
      @(posedge aclk);
      if (irq === 1'h1) tail++;
      else cyc++;
      n_int += int'(tint);
      n_rst += int'(tsr);
      n_pin += int'(!pin_n);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14};
    do_reset();
    for (int i = 0; i < 5; i++) rd(offs[i], 32'h0, 2'h0);
    rd(8'h18, 32'h6c, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h00, 32'h1235, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h10, 32'h2, 2'h0);
    wr(8'h00, 32'h2346, 2'h0);
    rd(8'h00, 32'h6, 2'h0);
    wstrb <= 4'h1;
    wr(8'h00, 32'h2341, 2'h0);
    wstrb <= 4'hf;
    rd(8'h00, 32'h6, 2'h0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 32'h3700 | 32'(c << 2) | 32'(c), 2'h0);
      rd(8'h04, 32'(c << 2) | 32'(c), 2'h0);
    end
    wr(8'h04, 32'h3f30, 2'h0);
    rd(8'h04, 32'h0f, 2'h0);
    wr(8'h0c, 32'h1, 2'h2);
    wr(8'h1c, 32'h1, 2'h2);
    rd(8'h1c, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h0);
    rd(8'h14, 32'h1, 2'h0);
    run(32'h2341);
    chk("quiet", n_int + n_rst + n_pin, 0);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    chk("irq_masked", irq, 1'h0);
    wr(8'h14, 32'h1, 2'h0);
    chk("irq_unmasked", irq, 1'h1);
    run(32'h234f);
    chk("n_int", n_int, 1);
    chk("n_rst", n_rst, 1);
    chk("n_pin", n_pin, 8);
    chk("period", 32'(cyc >= 32730 && cyc <= 32775), 1);
    wr(8'h08, 32'hc070, 2'h0);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h08, 32'hc071, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    last_reset_was_watchdog <= 1'h1;
    do_reset();
    rd(8'h18, 32'h53, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    final_report();
  end
endmodule // tb_top
